// ### dac_velocity_model.sv
`timescale 1ns/100ps
// Velocity DAC plus command amplifier, seen as a signed reference in milli-ips
module dac_velocity_model
  import seek_ref_pkg::*;
(
  // DAC word from the tables
  input  wire logic [VEL_W-1:0] code,
  input  wire logic             atten,
  // Analog reference
  output int                    mips
);
  // Offset current cancels the midpoint; each step is 873 milli-ips
  always_comb begin
    mips = (int'(code) - 64) * 873;
    // Attenuator divides the reference near the destination
    if (atten === 1'b1) begin
      mips = mips * 10 / 265;
    end
  end
endmodule

// ### seek_ref_pkg.sv
package seek_ref_pkg;

  // Track address and difference widths
  localparam int ADDR_W     = 9;
  localparam int LOW_W      = 8;
  localparam int PRES_W     = 10;
  localparam int VEL_W      = 7;
  localparam int TABLE_AW   = 9;
  localparam int TABLE_DEPTH = 512;
  localparam int ENTRY_W    = 9;

  // Field positions of a short-seek table entry, and the zone bit of the complemented present address
  localparam int ENT_DRIVE  = 8;
  localparam int ENT_ATTEN  = 7;
  localparam int VEL_SIGN   = 6;
  localparam int ZONE_BIT   = 9;

  // Selector limit in tracks
  localparam int SHORT_RANGE = 128;
  localparam logic [1:0] UPPER_FWD = 2'h0;
  localparam logic [1:0] UPPER_REV = 2'h3;

  // Velocity codes on the shared DAC word
  localparam logic [VEL_W-1:0] VEL_ZERO     = 7'h40;
  localparam logic [VEL_W-1:0] VEL_FWD_FULL = 7'h7F;
  localparam logic [VEL_W-1:0] VEL_REV_FULL = 7'h01;
  localparam logic [VEL_W-1:0] VEL_LOAD     = 7'h42;
  localparam logic [VEL_W-1:0] VEL_REV_SLOW = 7'h38;
  localparam logic [VEL_W-1:0] VEL_ONE_TRK  = 7'h6E;

  // Short-seek profile: knee distances and forward codes
  localparam int PROF_N    = 8;
  localparam int MAX_VEL_DIFF = 99;
  localparam int CODE_SPAN = 128;
  localparam int PROF_DIFF [PROF_N] = '{2, 3, 20, 40, 60, 80, 98, 99};
  localparam int PROF_CODE [PROF_N] = '{67, 69, 82, 95, 106, 117, 125, 127};

  // Overtravel point
  localparam logic [ADDR_W-1:0] FAR_TRACK = 9'h197;

  // Cool-down timing
  localparam int CLK_KHZ        = 50000;
  localparam int COOL_DOWN_MS   = 10000;
  localparam int EXTRA_DELAY_MS = 100;
  localparam int COOL_DOWN_CYC  = COOL_DOWN_MS * CLK_KHZ;
  localparam int EXTRA_DELAY_CYC = EXTRA_DELAY_MS * CLK_KHZ;
  localparam int CNT_W          = 32;

  // Positions of pins in the synchroniser vector
  localparam int PIN_N        = 9;
  localparam int PIN_HOME     = 0;
  localparam int PIN_SPEED    = 1;
  localparam int PIN_BRUSH    = 2;
  localparam int PIN_SPIN_OFF = 3;
  localparam int PIN_SAT      = 4;
  localparam int PIN_EXCESS   = 5;
  localparam int PIN_SERVO_EN = 6;
  localparam int PIN_ON_TRACK = 7;
  localparam int PIN_FIXED_XF = 8;

  // Drive states decoded by the state table
  typedef enum logic [3:0] {
    ROW_RETRACT, ROW_HOME_IDLE, ROW_LOAD, ROW_REV_RECAL, ROW_DETENT,
    ROW_FORWARD, ROW_REVERSE, ROW_UNLOAD_LOADED, ROW_UNLOAD_MOVING, ROW_ILLEGAL
  } state_row_type;

endpackage

// ### seek_velocity_reference.sv
//Operation
// - Nine-bit differencer: eight-bit plus one-bit adder
// - Add complemented present address plus one
// - Carry one forward, zero reverse
// - Short-seek table below 128 tracks
// - State table at 128 or more, or zero
// - At zero short table releases velocity
// - State table: 1.7, 7, 55 ips
// - Zero difference: zero velocity, detent mode
// - Short table velocity falls nearing destination
// - Codes: full forward, full reverse, midpoint
// - Difference low bit reaches table inverted
// - Maximum velocity at 99 or more tracks
// - One track away: large code, attenuate
// - Overtravel flag past 407 triggers recalibrate
// - Run permit: speed and sweep; off clears
// - Zone flag is complemented address top bit
// - State inputs: home, carry, zero; quadrature ignored
// - Ten states, tenth illegal
// - Spindle stopped, not home: retract
// - Motor saturating delays subsequent seeks
// - Current excess or servo loss: retract
// - Temperature compensation stays on during transfers
// - Home and run permitted: load forward
// - Loaded and not permitted: unload reverse
`timescale 1ns/100ps
module seek_velocity_reference
  import seek_ref_pkg::*;
#(
  parameter int COOL_CYC  = COOL_DOWN_CYC,   // Cool-down window
  parameter int EXTRA_CYC = EXTRA_DELAY_CYC  // Added seek delay while cooling
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               resetn,
  // Track addresses from the address registers
  input  wire logic [ADDR_W-1:0]  new_track_addr,
  input  wire logic [PRES_W-1:0]  present_addr_compl,
  // Seek start from the control logic
  input  wire logic               seek_request,
  // Drive state pins
  input  wire logic               carriage_home_switch,
  input  wire logic               spindle_at_speed,
  input  wire logic               brush_sweep_done,
  input  wire logic               spindle_off,
  input  wire logic               motor_saturating,
  input  wire logic               motor_current_excess,
  input  wire logic               servo_enable,
  input  wire logic               on_track,
  input  wire logic               fixed_transfer,
  // Velocity DAC
  output logic [VEL_W-1:0]        velocity_code,
  output logic                    velocity_sign_bit,
  output logic                    velocity_attenuate,
  output logic                    detent_mode,
  // Drive state outputs
  output logic                    spin_run_permit,
  output logic                    track_zone_msb,
  output logic                    difference_carry,
  output logic                    zero_difference,
  output logic                    recal_request,
  output logic                    emergency_retract,
  output logic                    seek_go,
  output logic                    temp_comp_enable,
  output logic                    state_illegal
);

  logic [PIN_N-1:0]    pin_meta_ff;   // First synchroniser stage
  logic [PIN_N-1:0]    pin_sync_ff;   // Second stage, safe to read
  logic                servo_en_d_ff; // Delayed copy for loss detect
  logic [ADDR_W-1:0]   diff;          // Raw difference
  logic                carry;         // Difference carry
  logic                zero_now;      // Difference equals zero
  logic                short_now;     // Within short-seek range
  logic [ENTRY_W-1:0]  short_entry_ff; // Registered table entry
  logic                short_en_ff;   // Stage-one selector copies
  logic                zero_ff;
  logic                carry_ff;
  logic                zone_ff;
  logic                far_ff;        // Overtravel flag
  logic                run_ff;        // Run permit
  state_row_type       row;           // Decoded state
  logic [VEL_W-1:0]    b_code;        // State table velocity
  logic                b_detent;      // State table asks for detent
  logic [VEL_W-1:0]    nxt_code;
  logic                nxt_atten;
  logic                nxt_detent;
  logic [VEL_W-1:0]    velocity_code_ff;
  logic                velocity_attenuate_ff;
  logic                detent_mode_ff;
  logic                recal_ff;
  logic                retract_ff;
  logic                illegal_ff;
  logic                temp_comp_ff;
  logic [CNT_W-1:0]    cool_cnt_ff;   // Remaining cool-down cycles
  logic [CNT_W-1:0]    delay_cnt_ff;  // Remaining seek delay
  logic                seek_pend_ff;  // Seek waiting out the delay
  logic                seek_go_ff;
  logic [PIN_N-1:0]    pins;
  logic [ADDR_W-1:0]   present_addr;  // True present track

  assign pins = {fixed_transfer, on_track, servo_enable, motor_current_excess,
                 motor_saturating, spindle_off, brush_sweep_done, spindle_at_speed,
                 carriage_home_switch};
  assign present_addr = ~present_addr_compl[ADDR_W-1:0];

  // Two flops on every pin; only the second stage is read
  for (genvar p = 0; p < PIN_N; p++) begin : g_sync
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        pin_meta_ff[p] <= 1'b0;
        pin_sync_ff[p] <= 1'b0;
      end else begin
        pin_meta_ff[p] <= pins[p];
        pin_sync_ff[p] <= pin_meta_ff[p];
      end
    end
  end

  // Differencer on the low nine address bits
  track_differencer u_diff (
    .new_addr      (new_track_addr),
    .present_compl (present_addr_compl[ADDR_W-1:0]),
    .diff          (diff),
    .carry         (carry)
  );

  // Selector: upper bits all clear forward, all set reverse (but not -128)
  always_comb begin
    zero_now  = carry && (diff == {ADDR_W{1'b0}});
    short_now = carry ? (diff[ADDR_W-1:ADDR_W-2] == UPPER_FWD)
                      : (diff[ADDR_W-1:ADDR_W-2] == UPPER_REV
                         && diff[ADDR_W-3:0] != {(ADDR_W-2){1'b0}});
  end

  // Table address: carry, eight low bits, low bit inverted
  short_seek_table u_table (
    .mclk     (mclk),
    .resetn   (resetn),
    .addr     ({carry, diff[LOW_W-1:1], ~diff[0]}),
    .entry_ff (short_entry_ff)
  );

  // Stage one holds the selector and zone beside the table read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      short_en_ff <= 1'b0;
      zero_ff     <= 1'b0;
      carry_ff    <= 1'b0;
      zone_ff     <= 1'b0;
    end else begin
      short_en_ff <= short_now;
      zero_ff     <= zero_now;
      carry_ff    <= carry;
      zone_ff     <= present_addr_compl[ZONE_BIT];
    end
  end

  // Overtravel: set past the far track, clear once behind track zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      far_ff   <= 1'b0;
      recal_ff <= 1'b0;
    end else begin
      if (present_addr_compl[ZONE_BIT] && present_addr > FAR_TRACK) begin
        far_ff <= 1'b1;
      end else if (!present_addr_compl[ZONE_BIT]) begin
        far_ff <= 1'b0;
      end
      recal_ff <= present_addr_compl[ZONE_BIT] && present_addr > FAR_TRACK && !far_ff;
    end
  end

  // Run permit; spindle shut-off overrides a coincident set
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      run_ff <= 1'b0;
    end else if (pin_sync_ff[PIN_SPIN_OFF]) begin
      run_ff <= 1'b0;
    end else if (pin_sync_ff[PIN_SPEED] && pin_sync_ff[PIN_BRUSH]) begin
      run_ff <= 1'b1;
    end
  end

  // State decode; quadrature bits are not inputs at all
  always_comb begin
    row = ROW_ILLEGAL;
    if (!run_ff && !pin_sync_ff[PIN_HOME]) begin
      row = zone_ff ? (carry_ff ? ROW_UNLOAD_MOVING : ROW_UNLOAD_LOADED)
                    : ROW_RETRACT;
    end else if (!run_ff) begin
      row = ROW_HOME_IDLE;
    end else if (!zone_ff && pin_sync_ff[PIN_HOME]) begin
      row = ROW_LOAD;
    end else if (!zone_ff && far_ff) begin
      row = ROW_REV_RECAL;
    end else if (zone_ff && !pin_sync_ff[PIN_HOME]) begin
      if (zero_ff) begin
        row = ROW_DETENT;
      end else begin
        row = carry_ff ? ROW_FORWARD : ROW_REVERSE;
      end
    end
  end

  // Velocity and detent per state
  always_comb begin
    b_code   = VEL_REV_SLOW;
    b_detent = 1'b0;
    unique case (row)
      ROW_RETRACT, ROW_REV_RECAL, ROW_UNLOAD_LOADED, ROW_UNLOAD_MOVING: begin
        b_code = VEL_REV_SLOW;
      end
      ROW_HOME_IDLE: begin
        b_code = VEL_ZERO;
      end
      ROW_LOAD: begin
        b_code = VEL_LOAD;
      end
      ROW_DETENT: begin
        b_code   = VEL_ZERO;
        b_detent = 1'b1;
      end
      ROW_FORWARD: begin
        b_code = VEL_FWD_FULL;
      end
      ROW_REVERSE: begin
        b_code = VEL_REV_FULL;
      end
      ROW_ILLEGAL: begin
        b_code = VEL_REV_SLOW;
      end
    endcase
  end

  // Shared DAC word: short table drives only when enabled and not floating
  always_comb begin
    if (short_en_ff && short_entry_ff[ENT_DRIVE]) begin
      nxt_code   = short_entry_ff[VEL_W-1:0];
      nxt_detent = 1'b0;
    end else begin
      nxt_code   = b_code;
      nxt_detent = b_detent;
    end
    nxt_atten = short_en_ff && short_entry_ff[ENT_ATTEN];
  end

  // Output register toward the DAC and servo switch
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      velocity_code_ff      <= VEL_ZERO;
      velocity_attenuate_ff <= 1'b0;
      detent_mode_ff        <= 1'b0;
      illegal_ff            <= 1'b0;
    end else begin
      velocity_code_ff      <= nxt_code;
      velocity_attenuate_ff <= nxt_atten;
      detent_mode_ff        <= nxt_detent;
      illegal_ff            <= (row == ROW_ILLEGAL);
    end
  end

  // Emergency retract latches until the carriage reaches home; set wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      servo_en_d_ff <= 1'b0;
      retract_ff    <= 1'b0;
    end else begin
      servo_en_d_ff <= pin_sync_ff[PIN_SERVO_EN];
      if (pin_sync_ff[PIN_EXCESS] || (servo_en_d_ff && !pin_sync_ff[PIN_SERVO_EN])) begin
        retract_ff <= 1'b1;
      end else if (pin_sync_ff[PIN_HOME]) begin
        retract_ff <= 1'b0;
      end
    end
  end

  // Cool-down restarts on every saturating cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cool_cnt_ff <= {CNT_W{1'b0}};
    end else if (pin_sync_ff[PIN_SAT]) begin
      cool_cnt_ff <= CNT_W'(COOL_CYC);
    end else if (cool_cnt_ff != {CNT_W{1'b0}}) begin
      cool_cnt_ff <= cool_cnt_ff - 1'b1;
    end
  end

  // Seek release: immediate when cool, held for the extra delay otherwise
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      delay_cnt_ff <= {CNT_W{1'b0}};
      seek_pend_ff <= 1'b0;
      seek_go_ff   <= 1'b0;
    end else begin
      seek_go_ff <= 1'b0;
      if (seek_request && !seek_pend_ff) begin
        if (cool_cnt_ff != {CNT_W{1'b0}} || pin_sync_ff[PIN_SAT]) begin
          seek_pend_ff <= 1'b1;
          delay_cnt_ff <= CNT_W'(EXTRA_CYC);
        end else begin
          seek_go_ff <= 1'b1;
        end
      end else if (seek_pend_ff) begin
        delay_cnt_ff <= delay_cnt_ff - 1'b1;
        if (delay_cnt_ff == CNT_W'(1)) begin
          seek_pend_ff <= 1'b0;
          seek_go_ff   <= 1'b1;
        end
      end
    end
  end

  // Compensation follows on-track only; a fixed-disc transfer never masks it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      temp_comp_ff <= 1'b0;
    end else begin
      temp_comp_ff <= pin_sync_ff[PIN_ON_TRACK];
    end
  end

  assign velocity_code      = velocity_code_ff;
  assign velocity_sign_bit  = velocity_code_ff[VEL_SIGN];
  assign velocity_attenuate = velocity_attenuate_ff;
  assign detent_mode        = detent_mode_ff;
  assign spin_run_permit    = run_ff;
  assign track_zone_msb     = zone_ff;
  assign difference_carry   = carry_ff;
  assign zero_difference    = zero_ff;
  assign recal_request      = recal_ff;
  assign emergency_retract  = retract_ff;
  assign seek_go            = seek_go_ff;
  assign temp_comp_enable   = temp_comp_ff;
  assign state_illegal      = illegal_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_cool_request;
    seek_request && !seek_pend_ff && cool_cnt_ff != {CNT_W{1'b0}};
  endsequence

  sequence s_hold_off;
    !seek_go_ff [*2];
  endsequence

  a_diff_value: assert property (diff == ADDR_W'(new_track_addr - present_addr))
    else $error("difference wrong");
  a_carry_dir: assert property (carry == (new_track_addr >= present_addr))
    else $error("carry direction wrong");
  a_short_drive: assert property (short_now && !zero_now ##1 short_entry_ff[ENT_DRIVE]
    |=> velocity_code_ff == $past(short_entry_ff[VEL_W-1:0]))
    else $error("short table not driving");
  a_zero_detent: assert property (row == ROW_DETENT
    |=> detent_mode_ff && velocity_code_ff == VEL_ZERO)
    else $error("no detent at zero");
  a_retract_home: assert property (!run_ff && !pin_sync_ff[PIN_HOME] && !zone_ff
    && !short_en_ff |=> velocity_code_ff == VEL_REV_SLOW)
    else $error("no retract");
  a_load_fwd: assert property (row == ROW_LOAD && !short_en_ff
    |=> velocity_code_ff == VEL_LOAD && !detent_mode_ff)
    else $error("no load");
  a_far_recal: assert property ($rose(far_ff) |-> $past(recal_ff) || recal_ff)
    else $error("overtravel without recal");
  a_run_off: assert property (pin_sync_ff[PIN_SPIN_OFF] |=> !run_ff)
    else $error("run permit stuck");
  a_retract_trip: assert property (pin_sync_ff[PIN_EXCESS] |=> retract_ff [*2])
    else $error("retract missing");
  a_seek_delay: assert property (s_cool_request |=> s_hold_off)
    else $error("seek not delayed");

endmodule

// ### short_seek_table.sv
`timescale 1ns/100ps
module short_seek_table
  import seek_ref_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // Lookup
  input  wire logic [TABLE_AW-1:0] addr,
  output logic      [ENTRY_W-1:0]  entry_ff
);

  // Entry: drive enable, attenuate, seven-bit velocity code
  function automatic logic [ENTRY_W-1:0] entry_for(input int a);
    int d;
    int mag;
    int fwd;
    int i;
    logic carry;
    logic atten;
    carry = a[8];
    // Seven low difference bits only, with the inverted low bit undone;
    // the eighth bit would push reverse distances past the mirror point
    d     = {a[6:1], ~a[0]};
    atten = 1'b0;
    fwd   = PROF_CODE[PROF_N-1];
    if (carry && d == 0) begin
      // Zero difference: velocity released, state table overlays
      return {1'b0, 1'b0, VEL_ZERO};
    end
    mag = carry ? d : CODE_SPAN - d;
    if (mag == 1) begin
      // Large code scaled down by the attenuator
      fwd   = VEL_ONE_TRK;
      atten = 1'b1;
    end else if (mag >= MAX_VEL_DIFF) begin
      fwd = PROF_CODE[PROF_N-1];
    end else begin
      // Straight lines between knees, falling toward the target
      for (i = 0; i < PROF_N - 1; i++) begin
        if (mag >= PROF_DIFF[i] && mag < PROF_DIFF[i+1]) begin
          fwd = PROF_CODE[i] + (mag - PROF_DIFF[i]) * (PROF_CODE[i+1] - PROF_CODE[i])
                / (PROF_DIFF[i+1] - PROF_DIFF[i]);
        end
      end
    end
    // Reverse codes mirror the forward ones about the midpoint
    if (!carry) begin
      fwd = CODE_SPAN - fwd;
    end
    return {1'b1, atten, fwd[VEL_W-1:0]};
  endfunction

  logic [ENTRY_W-1:0] rom [TABLE_DEPTH]; // Constant contents

  // One constant entry per address
  for (genvar g = 0; g < TABLE_DEPTH; g++) begin : g_rom
    localparam logic [ENTRY_W-1:0] ENTRY_VAL = entry_for(g);
    assign rom[g] = ENTRY_VAL;
  end

  // Registered read so the table looks like a clocked memory
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      entry_ff <= {ENTRY_W{1'b0}};
    end else begin
      entry_ff <= rom[addr];
    end
  end

endmodule

// ### tb_seek_velocity_reference.sv
`timescale 1ns/100ps
module tb_seek_velocity_reference;
  import seek_ref_pkg::*;
  // Short cool-down counts keep the run brief
  localparam int COOL  = 20;
  localparam int EXTRA = 5;
  logic              mclk = 0;
  logic              resetn = 0;
  logic [ADDR_W-1:0] new_track_addr = '0;
  logic [PRES_W-1:0] present_addr_compl = '1;
  logic              seek_request = 0;
  logic              carriage_home_switch = 0;
  logic              spindle_at_speed = 0;
  logic              brush_sweep_done = 0;
  logic              spindle_off = 0;
  logic              motor_saturating = 0;
  logic              motor_current_excess = 0;
  logic              servo_enable = 1;
  logic              on_track = 0;
  logic              fixed_transfer = 0;
  logic [VEL_W-1:0]  velocity_code;
  logic              velocity_sign_bit, velocity_attenuate, detent_mode;
  logic              spin_run_permit, track_zone_msb, difference_carry;
  logic              zero_difference, recal_request, emergency_retract;
  logic              seek_go, temp_comp_enable, state_illegal;
  int                num_errors = 0;
  int                num_checks = 0;
  int                cyc = 0;
  int                recals = 0;
  int                mips;
  int                n;
  logic [31:0]       seed = 32'd26754;
  // Directed track pairs: one track either way, zero, range edges, knees
  int                dp [10] = '{3, 4, 10, 0, 200, 0, 300, 32, 50, 50};
  int                dn [10] = '{4, 3, 10, 127, 72, 128, 200, 34, 149, 148};

  seek_velocity_reference #(.COOL_CYC(COOL), .EXTRA_CYC(EXTRA)) u_seek_velocity_reference (.*);
  dac_velocity_model u_dac_velocity_model (.code(velocity_code), .atten(velocity_attenuate),
                                           .mips(mips));

  // Clock and hang guard
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (recal_request === 1'b1) recals++;
    if (cyc == 6000) begin
      num_errors++;
      final_report();
    end
  end

  function automatic logic [31:0] xs(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  // Forward profile window; between knees only the bracket is known
  function automatic void bounds(int d, output int lo, output int hi);
    lo = 127;
    hi = 127;
    if (d == 1) begin
      lo = int'(VEL_ONE_TRK);
      hi = lo;
    end
    for (int i = 0; i < PROF_N - 1; i++) begin
      if (d >= PROF_DIFF[i] && d < PROF_DIFF[i+1]) begin
        lo = PROF_CODE[i];
        hi = (d == PROF_DIFF[i]) ? lo : PROF_CODE[i+1];
      end
    end
  endfunction

  task automatic chk(logic ok, string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic step(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Present p, new n with heads loaded in the data zone; answer lands two edges later
  task automatic vec(int p, int nw);
    int s, d, lo, hi;
    @(posedge mclk);
    present_addr_compl <= {1'b1, ~9'(p)};
    new_track_addr     <= 9'(nw);
    step(3);
    s = nw % 512 - p;
    d = (s < 0) ? -s : s;
    chk(difference_carry === (s >= 0), "carry");
    chk(zero_difference === (s == 0) && track_zone_msb === 1'b1, "zero or zone");
    chk(velocity_sign_bit === (s >= 0), "sign bit");
    chk(s > 0 ? mips > 0 : (s < 0 ? mips < 0 : mips == 0), "reference polarity");
    if (s == 0) begin
      chk(velocity_code === VEL_ZERO && detent_mode && !velocity_attenuate, "detent");
    end else if (d >= SHORT_RANGE) begin
      chk(velocity_code === (s > 0 ? VEL_FWD_FULL : VEL_REV_FULL) && !detent_mode,
          "long seek");
    end else begin
      bounds(d, lo, hi);
      if (s < 0) {lo, hi} = {CODE_SPAN - hi, CODE_SPAN - lo};
      chk(int'(velocity_code) >= lo && int'(velocity_code) <= hi, "profile");
      chk(velocity_attenuate === (d == 1) && !detent_mode, "attenuate");
    end
  endtask

  // Seek release latency counted from the edge that takes the request
  task automatic seek_lat(output int k);
    @(posedge mclk) seek_request <= 1;
    @(posedge mclk) seek_request <= 0;
    k = 1;
    #1;
    while (seek_go !== 1'b1 && k < 30) begin
      step(1);
      k++;
    end
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    chk(velocity_code === VEL_ZERO && !detent_mode && !seek_go, "reset values");
    resetn <= 1;
    // Home, not running: zero velocity, detent released
    carriage_home_switch <= 1;
    present_addr_compl   <= 10'h1FF;
    step(6);
    chk(velocity_code === VEL_ZERO && !detent_mode && !spin_run_permit, "home idle");
    @(posedge mclk);
    spindle_at_speed <= 1;
    brush_sweep_done <= 1;
    step(6);
    chk(spin_run_permit && velocity_code === VEL_LOAD && !detent_mode, "load");
    @(posedge mclk) carriage_home_switch <= 0;
    step(6);
    chk(state_illegal === 1'b1 && velocity_code === VEL_REV_SLOW, "illegal row");
    for (int i = 0; i < 10; i++) vec(dp[i], dn[i]);
    repeat (300) begin
      seed = xs(seed);
      n = int'(seed % 408);
      seed = xs(seed);
      if (seed[0]) vec(n, int'(seed % 512));
      else vec(n, (n + int'((seed >> 1) % 257) < 128) ? 0 : n + int'((seed >> 1) % 257) - 128);
    end
    // Overtravel past the far track asks for one recalibrate
    @(posedge mclk) present_addr_compl <= {1'b1, ~9'd408};
    step(6);
    chk(recals == 1, "recalibrate pulse");
    seek_lat(n);
    chk(n == 1, "cool seek");
    @(posedge mclk) motor_saturating <= 1;
    step(4);
    @(posedge mclk) motor_saturating <= 0;
    seek_lat(n);
    chk(n == EXTRA + 1, "delayed seek");
    step(40);
    seek_lat(n);
    chk(n == 1, "seek after cool-down");
    @(posedge mclk);
    on_track       <= 1;
    fixed_transfer <= 1;
    present_addr_compl <= '1;
    new_track_addr     <= '0;
    step(5);
    chk(temp_comp_enable === 1'b1, "compensation in transfer");
    @(posedge mclk) spindle_off <= 1;
    step(6);
    chk(!spin_run_permit && velocity_code === VEL_REV_SLOW && !detent_mode, "unload");
    @(posedge mclk) present_addr_compl <= 10'h1FF;
    step(6);
    chk(velocity_code === VEL_REV_SLOW, "retract home");
    @(posedge mclk) servo_enable <= 0;
    step(5);
    chk(emergency_retract === 1'b1, "servo loss");
    @(posedge mclk) carriage_home_switch <= 1;
    step(5);
    chk(emergency_retract === 1'b0, "retract cleared");
    @(posedge mclk);
    carriage_home_switch <= 0;
    motor_current_excess <= 1;
    step(5);
    chk(emergency_retract === 1'b1, "current excess");
    final_report();
  end
endmodule

// ### track_differencer.sv
`timescale 1ns/100ps
module track_differencer
  import seek_ref_pkg::*;
(
  // Addresses
  input  wire logic [ADDR_W-1:0] new_addr,
  input  wire logic [ADDR_W-1:0] present_compl,
  // Result
  output logic      [ADDR_W-1:0] diff,
  output logic                   carry
);

  logic [LOW_W:0] low_sum;  // Eight-bit adder with its carry
  logic [1:0]     top_sum;  // One-bit adder stage

  // Low byte adds the complement plus one through the carry-in
  always_comb begin
    low_sum = {1'b0, new_addr[LOW_W-1:0]} + {1'b0, present_compl[LOW_W-1:0]} + 9'h001;
  end

  // Ninth bit chained on the low carry; its carry marks direction
  always_comb begin
    top_sum = {1'b0, new_addr[ADDR_W-1]} + {1'b0, present_compl[ADDR_W-1]}
              + {1'b0, low_sum[LOW_W]};
  end

  assign diff  = {top_sum[0], low_sum[LOW_W-1:0]};
  assign carry = top_sum[1];

endmodule
